// ===== logic/psar_consts.svh
// Offsets, field positions, reset values and widths of the PHY status and
// ability register bank. Assumes inclusion by bare name from design files.
`ifndef PSAR_CONSTS_SVH
`define PSAR_CONSTS_SVH

// Register indices; byte address is four times the index
`define PSAR_IDX_CONTROL 5'h00
`define PSAR_IDX_MODE_STATUS 5'h01
`define PSAR_IDX_IDENT_HIGH 5'h02
`define PSAR_IDX_IDENT_LOW 5'h03
`define PSAR_IDX_ADVERT 5'h04
`define PSAR_IDX_PARTNER 5'h05
`define PSAR_IDX_PAGE_SEL 5'h1f

// Page selection
`define PSAR_PAGE_W 2
`define PSAR_PAGE_LAST 2'h2
`define PSAR_PAGE_RESET 2'h0

// Control register fields
`define PSAR_CTL_SPEED0 13
`define PSAR_CTL_AN_EN 12
`define PSAR_CTL_DUPLEX 8
`define PSAR_CTL_SPEED1 6
`define PSAR_CTL_RESET 16'h1040

// Mode status fields
`define PSAR_MS_ABILITY_CONST 16'h7909
`define PSAR_MS_AN_DONE 5
`define PSAR_MS_RFAULT 4
`define PSAR_MS_LINK 2
`define PSAR_MS_JABBER 1

// Identifier fields
`define PSAR_ID_MODEL_HI 9
`define PSAR_ID_MODEL_LO 4
`define PSAR_ID_REV_HI 3
`define PSAR_ID_REV_LO 0

// Advertisement fields and writable mask
`define PSAR_ADV_WMASK 16'hadff
`define PSAR_ADV_RESET 16'h01e1

// Partner ability fields
`define PSAR_LP_ACK 14
`define PSAR_LP_ASYM 11
`define PSAR_LP_T4 9
`define PSAR_LP_RMASK 16'hafe0
`define PSAR_LP_SEL_HI 4
`define PSAR_LP_RESET 16'h0000

`endif

// ===== logic/psar_pkg.sv
// Types shared by the PHY status and ability register bank.
// Assumes the constants header is available for field layouts.
package psar_pkg;

  typedef logic [15:0] psar_word_type;
  typedef logic [4:0] psar_index_type;

  // Bus slave phase, Gray coded from idle through wait to done
  typedef enum logic [1:0] {
    PSAR_IDLE = 2'b00,
    PSAR_WAIT = 2'b01,
    PSAR_DONE = 2'b11
  } psar_phase_type;

endpackage : psar_pkg

// ===== logic/psar_acc_if.sv
// Register access carrier between the bus slave and the register bank.
// Assumes both ends run on the same management clock.
interface psar_acc_if;
  psar_pkg::psar_index_type index;
  psar_pkg::psar_word_type wdata;
  psar_pkg::psar_word_type rdata;
  logic wr_pulse;
  logic rd_pulse;
  logic err;

  modport slave (
    output index,
    output wdata,
    output wr_pulse,
    output rd_pulse,
    input rdata,
    input err
  );

  modport bank (
    input index,
    input wdata,
    input wr_pulse,
    input rd_pulse,
    output rdata,
    output err
  );
endinterface : psar_acc_if

// ===== logic/psar_apb_slave.sv
// APB slave front end with one wait state; read data and error registered.
// Assumes an APB master on pclk and a register bank behind the carrier.
`include "psar_consts.svh"

module psar_apb_slave (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register access side
  psar_acc_if.slave acc
);

  psar_pkg::psar_phase_type phase_q;
  psar_pkg::psar_phase_type phase_d;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic pready_q;
  logic access;
  logic commit;
  logic sample;
  logic misaligned;

  // Request decode
  assign access = psel & penable;
  assign sample = access & (phase_q == psar_pkg::PSAR_IDLE);
  assign misaligned = (paddr[1:0] != 2'h0) | paddr[7];
  assign acc.index = paddr[6:2];
  assign acc.wdata = pwdata[15:0];
  // Misaligned requests complete with an error and touch nothing
  assign commit = (phase_q == psar_pkg::PSAR_WAIT) & access & ~misaligned;
  assign acc.wr_pulse = commit & pwrite;
  assign acc.rd_pulse = commit & ~pwrite;

  // Phase sequence: sample, then answer, then back to idle
  always_comb begin
    phase_d = phase_q;
    unique case (phase_q)
      psar_pkg::PSAR_IDLE: if (access) phase_d = psar_pkg::PSAR_WAIT;
      psar_pkg::PSAR_WAIT: phase_d = psar_pkg::PSAR_DONE;
      psar_pkg::PSAR_DONE: phase_d = psar_pkg::PSAR_IDLE;
      default: phase_d = psar_pkg::PSAR_IDLE;
    endcase
  end

  // Phase register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= psar_pkg::PSAR_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // Answer capture in the first access cycle; ready and error stand one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
      pready_q <= 1'b0;
    end else begin
      pready_q <= sample;
      pslverr_q <= sample & (misaligned | acc.err);
      if (sample) begin
        prdata_q <= (pwrite | misaligned | acc.err) ? 32'h0000_0000 :
                    {16'h0000, acc.rdata};
      end
    end
  end

  // Answer outputs straight from flip-flops
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pready = pready_q;

endmodule : psar_apb_slave

// ===== logic/psar_link_latch.sv
// Latching-low link status bit, reloaded by a completed status read.
// Assumes link_up comes from logic on pclk.
module psar_link_latch (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link state and read event
  input wire logic link_up,
  input wire logic status_read,
  // Latched view
  output logic link_latched
);

  logic latch_q;
  logic latch_d;

  // Loss holds the bit low until a read; the read reloads the live state
  assign latch_d = status_read ? link_up : (latch_q & link_up);

  // Latch register, clear after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  assign link_latched = latch_q;

endmodule : psar_link_latch

// ===== logic/psar_top.sv
// PHY status and ability register bank: control, mode status, identifier,
// advertisement and partner ability registers behind an APB slave.
// Assumes status inputs come from link and negotiation logic on pclk.
// Assumes an APB master on pclk using word-aligned byte addresses.
// Assumes partner pages arrive as one-cycle capture pulses.
//
// Register access over APB was left to the implementer.
`include "psar_consts.svh"

module psar_top #(
  parameter logic [15:0] OUI_HIGH = 16'h1234,    // Arbitrary value
  parameter logic [5:0] OUI_LOW = 6'h2a,         // Arbitrary value
  parameter logic [5:0] MODEL_RESET = 6'h15,     // Arbitrary value
  parameter logic [3:0] REVISION_RESET = 4'h1    // Arbitrary value
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link and negotiation status
  input wire logic link_up,
  input wire logic jabber_det,
  input wire logic remote_fault_det,
  input wire logic an_complete,
  // Received partner base page
  input wire logic [15:0] partner_page,
  input wire logic partner_page_valid,
  // Negotiated result
  input wire logic [1:0] neg_speed,
  input wire logic neg_full_duplex,
  // Configuration to link logic
  output logic an_enable,
  output logic [15:0] adv_page,
  output logic [1:0] speed_sel,
  output logic full_duplex
);

  psar_acc_if acc ();

  // Register state
  // Every stored field of the bank lives here.
  // Live status bits other than the latched
  // link bit are not stored: they are read
  // straight from the link logic, so a read
  // shows the present condition.
  logic [15:0] ctrl_q;
  logic [5:0] model_q;
  logic [3:0] rev_q;
  logic [15:0] adv_q;
  logic [15:0] lp_q;
  logic [1:0] page_q;
  logic [1:0] speed_q;
  logic duplex_q;
  logic link_latched;

  // Write decode
  // Named strobes, one per writable register,
  // so each register write below is a plain
  // enable and no clocked process decodes addresses.
  logic page_ok;
  logic idx_main;
  logic wr_ctrl;
  logic wr_ident;
  logic wr_adv;
  logic wr_lp;
  logic wr_page;
  logic rd_status;

  // Next values and read words
  logic [15:0] adv_d;
  logic [15:0] lp_d;
  logic [15:0] status_word;
  logic [15:0] ident_low_word;
  logic [15:0] rd_main;
  logic [1:0] manual_speed;

  // Bus front end
  // One fixed wait state on every transfer.
  // Read data and error are taken in the first
  // access cycle; the register side effect
  // lands at the completion edge, so a read
  // reports the state before its own reload.
  psar_apb_slave u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .acc(acc)
  );

  // Page check and index decode
  // Pages 0 to 2 all map the same main set, so
  // the page only gates access, never the data.
  // Page 3 turns every main index into an error
  // while the page register stays reachable.
  assign page_ok = (page_q <= `PSAR_PAGE_LAST);
  assign idx_main = page_ok & (acc.index <= `PSAR_IDX_PARTNER);
  assign wr_ctrl = acc.wr_pulse & idx_main &
                   (acc.index == `PSAR_IDX_CONTROL);
  assign wr_ident = acc.wr_pulse & idx_main &
                    (acc.index == `PSAR_IDX_IDENT_LOW);
  assign wr_adv = acc.wr_pulse & idx_main &
                  (acc.index == `PSAR_IDX_ADVERT);
  assign wr_lp = acc.wr_pulse & idx_main &
                 (acc.index == `PSAR_IDX_PARTNER);
  assign wr_page = acc.wr_pulse & (acc.index == `PSAR_IDX_PAGE_SEL);
  assign rd_status = acc.rd_pulse & idx_main &
                     (acc.index == `PSAR_IDX_MODE_STATUS);

  // Unmapped index or page outside the main set answers with an error
  // The page register answers on every page;
  // otherwise a bad page could never be left.
  // Refused accesses change no register.
  assign acc.err = ~(idx_main | (acc.index == `PSAR_IDX_PAGE_SEL));

  // Latching-low link bit, reloaded by a status read
  // Only a completed, error-free read of mode
  // status reloads it; a refused or misaligned
  // access leaves a latched loss in place.
  // A loss in the reload cycle still wins.
  psar_link_latch u_link (
    .pclk(pclk),
    .presetn(presetn),
    .link_up(link_up),
    .status_read(rd_status),
    .link_latched(link_latched)
  );

  // Mode status word: fixed abilities plus live status bits and the latched link bit
  // Ability bits are constants: no 100BASE-T4
  // and no 100BASE-T2 path exists behind this
  // bank, so those bits can never read 1.
  // Live bits are taken with the read data in
  // the first access cycle of the transfer.
  always_comb begin
    status_word = `PSAR_MS_ABILITY_CONST;
    status_word[`PSAR_MS_AN_DONE] = an_complete;
    status_word[`PSAR_MS_RFAULT] = remote_fault_det;
    status_word[`PSAR_MS_LINK] = link_latched;
    status_word[`PSAR_MS_JABBER] = jabber_det;
  end

  // Identifier low word: fixed organisation bits above model and revision
  // Organisation bits are parameters only and
  // ignore writes; model and revision are
  // stored and can be replaced by the host.
  assign ident_low_word = {OUI_LOW, model_q, rev_q};

  // Read selection
  // Unmapped indices read 0; the bus slave
  // also forces 0 on writes and refusals, so
  // stale contents never leak onto the bus.
  // The page is checked in the error path.
  always_comb begin
    rd_main = 16'h0000;
    unique case (acc.index)
      `PSAR_IDX_CONTROL: rd_main = ctrl_q;
      `PSAR_IDX_MODE_STATUS: rd_main = status_word;
      `PSAR_IDX_IDENT_HIGH: rd_main = OUI_HIGH;
      `PSAR_IDX_IDENT_LOW: rd_main = ident_low_word;
      `PSAR_IDX_ADVERT: rd_main = adv_q;
      `PSAR_IDX_PARTNER: rd_main = lp_q;
      `PSAR_IDX_PAGE_SEL: rd_main = {14'h0000, page_q};
      default: rd_main = 16'h0000;
    endcase
  end
  assign acc.rdata = rd_main;

  // Control register: negotiation enable, manual speed and duplex
  // Only enable, speed and duplex are stored;
  // every other control bit reads 0 and a
  // write to it is dropped without an error.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `PSAR_CTL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= acc.wdata & ((16'h0001 << `PSAR_CTL_SPEED0) |
                             (16'h0001 << `PSAR_CTL_AN_EN) |
                             (16'h0001 << `PSAR_CTL_DUPLEX) |
                             (16'h0001 << `PSAR_CTL_SPEED1));
    end
  end

  // Page select register
  // Written on any page; a value above the
  // last main page is kept as written and
  // then refused on each main access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= `PSAR_PAGE_RESET;
    end else if (wr_page) begin
      page_q <= acc.wdata[`PSAR_PAGE_W-1:0];
    end
  end

  // Writable model and revision fields
  // Reset loads the strap values given by the
  // parameters, which follow the silicon
  // build; a write replaces both fields.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      model_q <= MODEL_RESET;
      rev_q <= REVISION_RESET;
    end else if (wr_ident) begin
      model_q <= acc.wdata[`PSAR_ID_MODEL_HI:`PSAR_ID_MODEL_LO];
      rev_q <= acc.wdata[`PSAR_ID_REV_HI:`PSAR_ID_REV_LO];
    end
  end

  // Advertisement next value: only the writable bits change
  // Reserved bits keep reading 0 whatever the
  // host writes, so the offered page never
  // carries bits the partner cannot decode.
  assign adv_d = (adv_q & ~`PSAR_ADV_WMASK) |
                 (acc.wdata & `PSAR_ADV_WMASK);

  // Advertisement register
  // The stored page goes straight to the link
  // logic, so a write changes what is offered
  // from the next clock on; a renegotiation
  // is needed before the partner sees it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_q <= `PSAR_ADV_RESET;
    end else if (wr_adv) begin
      adv_q <= adv_d;
    end
  end

  // Partner page capture; host may rewrite only asymmetric pause
  // A page arriving in the same cycle as a
  // host write wins: the received word is the
  // newer truth about the partner.
  // The reserved bit is masked off on capture
  // and the acknowledge bit is set with it.
  always_comb begin
    lp_d = lp_q;
    if (wr_lp) begin
      lp_d[`PSAR_LP_ASYM] = acc.wdata[`PSAR_LP_ASYM];
    end
    if (partner_page_valid) begin
      lp_d = partner_page & `PSAR_LP_RMASK;
      lp_d[`PSAR_LP_SEL_HI:0] = partner_page[`PSAR_LP_SEL_HI:0];
      lp_d[`PSAR_LP_ACK] = 1'b1;
    end
  end

  // Partner ability register
  // Clear after reset: nothing is known of
  // the partner until its first code word.
  // Loaded every cycle from the next value.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lp_q <= `PSAR_LP_RESET;
    end else begin
      lp_q <= lp_d;
    end
  end

  // Manual speed code from the control register
  // The two speed bits sit apart in control;
  // joined here into one code for the mode
  // logic, high bit first.
  assign manual_speed = {ctrl_q[`PSAR_CTL_SPEED1], ctrl_q[`PSAR_CTL_SPEED0]};

  // Effective speed and duplex: negotiation overrides manual settings
  // Registered so the link logic sees a clean
  // change one cycle after the source moves,
  // never a glitch while the enable flips.
  // Manual values matter only with it clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_q <= 2'h0;
      duplex_q <= 1'b0;
    end else if (ctrl_q[`PSAR_CTL_AN_EN]) begin
      speed_q <= neg_speed;
      duplex_q <= neg_full_duplex;
    end else begin
      speed_q <= manual_speed;
      duplex_q <= ctrl_q[`PSAR_CTL_DUPLEX];
    end
  end

  // Outputs toward the link logic
  // Each output is a stored bit, so nothing
  // combinational reaches the link side and
  // the enable reads 1 straight from reset.
  assign an_enable = ctrl_q[`PSAR_CTL_AN_EN];
  assign adv_page = adv_q;
  assign speed_sel = speed_q;
  assign full_duplex = duplex_q;

endmodule : psar_top

// ===== tb/psar_host_model.sv
// Bus master model for the register bank, one APB transfer per call.
// Assumes xfer is called just after a rising pclk edge.
module psar_host_model (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Setup, access until pready, then release
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Stale data no longer shown
  endtask : xfer
endmodule : psar_host_model

// ===== tb/psar_top_assertions.sv
// Port checks on the status and ability register bank.
// Assumes one pclk domain; attached by the bind below.
module psar_top_assertions #(
  parameter logic [15:0] OUI_HIGH = 16'h1234
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status and configuration
  input wire logic link_up,
  input wire logic jabber_det,
  input wire logic remote_fault_det,
  input wire logic an_complete,
  input wire logic [1:0] neg_speed,
  input wire logic neg_full_duplex,
  input wire logic an_enable,
  input wire logic [15:0] adv_page,
  input wire logic [1:0] speed_sel,
  input wire logic full_duplex
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed accesses by kind
  wire ok_rd = pready && !pwrite && !pslverr;
  wire rd_ms = ok_rd && paddr == 8'h04;
  wire wr_adv = pready && pwrite && !pslverr && paddr == 8'h10;

  property p_ms_const;
    rd_ms |-> prdata[15:9] == 7'h3c;
  endproperty
  a_ms_const: assert property (p_ms_const)
    else $error("mode ability bits wrong");
  property p_ms_ext;
    rd_ms |-> prdata[8];
  endproperty
  a_ms_ext: assert property (p_ms_ext)
    else $error("extended status flag low");
  property p_ms_able;
    rd_ms |-> prdata[3] && prdata[0];
  endproperty
  a_ms_able: assert property (p_ms_able)
    else $error("ability flags low");
  property p_ms_live;
    rd_ms |-> prdata[5:4] == {$past(an_complete), $past(remote_fault_det)}
      && prdata[1] == $past(jabber_det);
  endproperty
  a_ms_live: assert property (p_ms_live)
    else $error("live status bits wrong");
  property p_link;
    rd_ms && !$past(link_up) && !$past(link_up, 2) |-> !prdata[2];
  endproperty
  a_link: assert property (p_link)
    else $error("link bit high while down");
  property p_id;
    ok_rd && paddr == 8'h08 |-> prdata[15:0] == OUI_HIGH;
  endproperty
  a_id: assert property (p_id)
    else $error("identifier high wrong");
  property p_adv_wr;
    wr_adv |=> adv_page == ($past(pwdata[15:0]) & 16'hadff);
  endproperty
  a_adv_wr: assert property (p_adv_wr)
    else $error("advertisement write wrong");
  property p_adv_rd;
    ok_rd && paddr == 8'h10 |-> prdata[15:0] == adv_page;
  endproperty
  a_adv_rd: assert property (p_adv_rd)
    else $error("advertisement read differs");
  property p_neg;
    an_enable && $past(an_enable) && $past(presetn) |->
      speed_sel == $past(neg_speed) && full_duplex == $past(neg_full_duplex);
  endproperty
  a_neg: assert property (p_neg)
    else $error("negotiated mode not applied");
endmodule : psar_top_assertions

bind psar_top psar_top_assertions #(.OUI_HIGH(OUI_HIGH)) i_chk (
  .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link_up(link_up), .jabber_det(jabber_det),
  .remote_fault_det(remote_fault_det), .an_complete(an_complete),
  .neg_speed(neg_speed), .neg_full_duplex(neg_full_duplex),
  .an_enable(an_enable), .adv_page(adv_page), .speed_sel(speed_sel),
  .full_duplex(full_duplex)
);

// ===== tb/tb.sv
// Self-checking bench for the status and ability register bank.
// Assumes the host model drives the bus and the bench the status pins.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] OHI = 16'h5a3c; // Arbitrary value
  localparam logic [15:0] ID3 = 16'h3e13; // Arbitrary value
  localparam logic [15:0] ID3W = {ID3[15:10], 10'h3ff};
  typedef struct packed {
    logic w; logic [7:0] a; logic [15:0] d; logic [15:0] x; logic e;
  } psar_row_type;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic link_up = 0, jabber_det = 0, remote_fault_det = 0, an_complete = 0;
  logic [15:0] partner_page = 0, adv_page;
  logic partner_page_valid = 0, neg_full_duplex = 0, an_enable, full_duplex;
  logic [1:0] neg_speed = 0, speed_sel;
  int mismatches = 0, n_checks = 0, cycles = 0;
  // Reset values, access kinds, pages and refusals
  psar_row_type rows [0:21] = '{
    '{0, 8'h04, 0, 16'h7909, 0}, '{0, 8'h08, 0, OHI, 0},
    '{0, 8'h0c, 0, ID3, 0}, '{0, 8'h10, 0, 16'h01e1, 0},
    '{0, 8'h14, 0, 16'h0, 0}, '{1, 8'h10, 16'hffff, 0, 0},
    '{0, 8'h10, 0, 16'hadff, 0}, '{1, 8'h04, 0, 0, 0},
    '{0, 8'h04, 0, 16'h7909, 0}, '{1, 8'h08, 0, 0, 0},
    '{0, 8'h08, 0, OHI, 0}, '{1, 8'h0c, 16'hffff, 0, 0},
    '{0, 8'h0c, 0, ID3W, 0}, '{1, 8'h14, 16'hffff, 0, 0},
    '{0, 8'h14, 0, 16'h0800, 0}, '{1, 8'h7c, 3, 0, 0},
    '{0, 8'h04, 0, 0, 1}, '{1, 8'h7c, 2, 0, 0},
    '{0, 8'h0c, 0, ID3W, 0}, '{1, 8'h7c, 0, 0, 0},
    '{0, 8'h18, 0, 0, 1}, '{0, 8'h05, 0, 0, 1}};

  psar_top #(.OUI_HIGH(OHI), .OUI_LOW(ID3[15:10]), .MODEL_RESET(ID3[9:4]),
    .REVISION_RESET(ID3[3:0])) i_psar_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_up(link_up),
    .jabber_det(jabber_det), .remote_fault_det(remote_fault_det),
    .an_complete(an_complete), .partner_page(partner_page),
    .partner_page_valid(partner_page_valid), .neg_speed(neg_speed),
    .neg_full_duplex(neg_full_duplex), .an_enable(an_enable),
    .adv_page(adv_page), .speed_sel(speed_sel), .full_duplex(full_duplex));
  psar_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Clock and cycle ceiling
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic check(input string n, input logic [31:0] e,
      input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : check

  task automatic acc(input logic w, input logic [7:0] a,
      input logic [15:0] d, input logic [15:0] x, input logic e);
    logic [31:0] r;
    logic s;
    u_host.xfer(w, a, {16'h0, d}, r, s);
    check("pslverr", {31'h0, e}, {31'h0, s});
    if (!w && !e) check("prdata", {16'h0, x}, r);
  endtask : acc

  task automatic page(input logic [15:0] p);
    @(posedge pclk);
    partner_page <= p;
    partner_page_valid <= 1'b1;
    @(posedge pclk);
    partner_page_valid <= 1'b0;
    partner_page <= ~p;
  endtask : page

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) acc(rows[i].w, rows[i].a, rows[i].d, rows[i].x,
      rows[i].e);
    acc(1, 8'h11, 0, 0, 1);
    check("adv_page", 16'hadff, adv_page);
    $display("test rows done");
    {an_complete, remote_fault_det, jabber_det, link_up} <= 4'hf;
    acc(0, 8'h04, 0, 16'h793b, 0);
    acc(0, 8'h04, 0, 16'h793f, 0);
    link_up <= 1'b0;
    @(posedge pclk);
    link_up <= 1'b1;
    acc(0, 8'h04, 0, 16'h793b, 0);
    acc(0, 8'h04, 0, 16'h793f, 0);
    {an_complete, remote_fault_det, jabber_det, link_up} <= 4'h0;
    acc(0, 8'h04, 0, 16'h7909, 0);
    $display("test status done");
    page(16'hffff);
    acc(0, 8'h14, 0, 16'hefff, 0);
    acc(1, 8'h14, 0, 0, 0);
    acc(0, 8'h14, 0, 16'he7ff, 0);
    page(16'h0001);
    acc(0, 8'h14, 0, 16'h4001, 0);
    $display("test partner done");
    neg_speed <= 2'h2;
    neg_full_duplex <= 1'b1;
    repeat (3) @(posedge pclk);
    check("speed_sel", 2, speed_sel);
    check("an_enable", 1, an_enable);
    check("full_duplex", 1, full_duplex);
    neg_full_duplex <= 1'b0;
    acc(1, 8'h00, 16'h2140, 0, 0);
    repeat (3) @(posedge pclk);
    check("speed_sel", 3, speed_sel);
    check("full_duplex", 1, full_duplex);
    $display("test mode done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check("adv_page", 16'h01e1, adv_page);
    acc(0, 8'h14, 0, 0, 0);
    acc(0, 8'h0c, 0, ID3, 0);
    $display("test reset done");
    end_of_test();
  end
endmodule : tb
